/* File: hw/sigma_delta_decimation_filter.sv */
//--------------------------------------------------------------
// Purpose: decimation chain, word fifo and wishbone registers
// Assumes: modulator bit and pins are asynchronous to clock
// Notes:   parallel pin a high selects /32, pin b high low-pass
//--------------------------------------------------------------
`timescale 1ns/1ps

//--------------------------------------------------------------
// word fifo
//--------------------------------------------------------------
module sdf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             nrst,
	// filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// draining side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];       // storage
	logic [AW-1:0]    wp_r, wp_nxt;        // write pointer
	logic [AW-1:0]    rp_r, rp_nxt;        // read pointer
	logic [AW:0]      cnt_r, cnt_nxt;      // words held
	logic             push, pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		wp_nxt  = push ? AW'((wp_r == AW'(DEPTH-1)) ? 0 : wp_r + 1'b1) : wp_r;
		rp_nxt  = pop ? AW'((rp_r == AW'(DEPTH-1)) ? 0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// pointers reset, storage needs none
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

//--------------------------------------------------------------
// filter top
//--------------------------------------------------------------
module sigma_delta_decimation_filter
	import sdf_pkg::*;
(
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      nrst,
	// modulator and select pins
	input  wire logic                      modulator_bit,
	input  wire logic                      serial_mode,
	input  wire logic                      parallel_rate_select_a,
	input  wire logic                      parallel_rate_select_b,
	input  wire logic                      serial_rate_select,
	input  wire logic                      serial_response_select,
	// decimated word stream
	output logic [sdf_pkg::WORD_W-1:0]     word_r,
	output logic                           word_valid_r,
	// wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic [31:0]                    wb_dat_o,
	output logic                           wb_ack_o
);
	import sdf_pkg::*;

	//----------------------------------------------------------
	// pin synchronisers
	//----------------------------------------------------------
	localparam int NP = 6;
	logic [NP-1:0] pin_raw;              // async pins
	logic [NP-1:0] s1_r, s2_r;           // two-stage sync
	assign pin_raw = {serial_response_select, serial_rate_select,
		parallel_rate_select_b, parallel_rate_select_a,
		serial_mode, modulator_bit};

	// only s2_r is ever looked at
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
		end
	end

	//----------------------------------------------------------
	// mode decode
	//----------------------------------------------------------
	logic by32;                           // low rate chosen
	logic lowpass_sel;                    // low-pass requested
	logic bandpass;                       // band-pass in force
	logic run_r, run_nxt;                 // ctrl run bit

	always_comb begin
		if (s2_r[1]) begin
			by32        = s2_r[4];
			lowpass_sel = s2_r[5];
		end else begin
			by32        = s2_r[2];
			lowpass_sel = s2_r[3];
		end
		bandpass = by32 && !lowpass_sel;
	end

	//----------------------------------------------------------
	// half-rate stage cascade
	//----------------------------------------------------------
	logic [ACC_W-1:0] stg_in  [STAGES+1]; // stage inputs, [0] is modulator
	logic             stg_vld [STAGES+1]; // strobes into each stage

	// a one gives plus full scale, a zero minus full scale
	assign stg_in[0]  = s2_r[0] ? FS_POS : FS_NEG;
	assign stg_vld[0] = run_r;            // a bit every clock while run_r is set

	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : stage
			logic [ACC_W-1:0] x1_r, x1_nxt, x2_r, x2_nxt; // delay line
			logic [ACC_W-1:0] y_r, y_nxt;                 // stage output
			logic             ph_r, ph_nxt;               // decimate phase
			logic             v_r, v_nxt;                 // output strobe
			logic [SUM_W-1:0] sum;
			logic [SUM_W-1:0] xe, x1e, x2e;

			// sign-extend taps to the sum width
			assign xe  = SUM_W'($signed(stg_in[g]));
			assign x1e = SUM_W'($signed(x1_r));
			assign x2e = SUM_W'($signed(x2_r));

			// last stage turns high-pass when band-pass is on:
			// the upper half-band then folds below clock/64
			always_comb begin
				if (g == BY32_IDX && bandpass) begin
					sum = xe - (x1e <<< 1) + x2e;
				end else begin
					sum = xe + (x1e <<< 1) + x2e;
				end
				x1_nxt = x1_r;
				x2_nxt = x2_r;
				ph_nxt = ph_r;
				y_nxt  = y_r;
				v_nxt  = 1'b0;
				if (stg_vld[g]) begin
					x1_nxt = stg_in[g];
					x2_nxt = x1_r;
					ph_nxt = !ph_r;
					if (ph_r) begin       // every second input
						y_nxt = ACC_W'($signed(sum) >>> TAP_SHIFT);
						v_nxt = 1'b1;
					end
				end
			end

			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					x1_r <= '0;
					x2_r <= '0;
					y_r  <= '0;
					ph_r <= 1'b0;
					v_r  <= 1'b0;
				end else begin
					x1_r <= x1_nxt;
					x2_r <= x2_nxt;
					y_r  <= y_nxt;
					ph_r <= ph_nxt;
					v_r  <= v_nxt;
				end
			end

			assign stg_in[g+1]  = y_r;
			assign stg_vld[g+1] = v_r;
		end
	endgenerate

	//----------------------------------------------------------
	// output tap selection and word port
	//----------------------------------------------------------
	logic [WORD_W-1:0] sel_word;          // chosen stage output
	logic              sel_vld;           // its strobe
	logic [WORD_W-1:0] word_nxt;
	logic              word_valid_nxt;

	always_comb begin
		if (by32) begin
			sel_word = WORD_W'(stg_in[BY32_IDX+1]);
			sel_vld  = stg_vld[BY32_IDX+1];
		end else begin
			sel_word = WORD_W'(stg_in[BY16_IDX+1]);
			sel_vld  = stg_vld[BY16_IDX+1];
		end
		word_nxt       = sel_vld ? sel_word : word_r;
		word_valid_nxt = sel_vld;         // one pulse per word
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			word_r       <= '0;
			word_valid_r <= 1'b0;
		end else begin
			word_r       <= word_nxt;
			word_valid_r <= word_valid_nxt;
		end
	end

	//----------------------------------------------------------
	// word fifo toward the register bus
	//----------------------------------------------------------
	logic              f_in_ready;        // room for a word
	logic              f_out_valid;       // a word waits
	logic [WORD_W-1:0] f_out_data;
	logic              f_pop;             // data register read

	// the converter cannot wait, so a full fifo drops and flags
	sdf_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (word_valid_r),
		.in_data   (word_r),
		.in_ready  (f_in_ready),
		.out_valid (f_out_valid),
		.out_data  (f_out_data),
		.out_ready (f_pop)
	);

	//----------------------------------------------------------
	// wishbone registers
	//----------------------------------------------------------
	logic        req;                     // new access this cycle
	logic        ack_nxt;
	logic [31:0] dat_nxt;
	logic        ovf_r, ovf_nxt;          // sticky drop flag
	logic        ovf_set;

	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ovf_set = word_valid_r && !f_in_ready;
	assign f_pop   = req && !wb_we_i && (wb_adr_i == DATA_OFS);

	// single-wait answer: ack one edge after the request is seen
	always_comb begin
		ack_nxt = req;
		dat_nxt = '0;                     // unmapped reads give zero
		run_nxt = run_r;
		ovf_nxt = ovf_r || ovf_set;       // set beats clear
		if (req && wb_we_i) begin
			if (wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
				run_nxt = wb_dat_i[CTRL_RUN];
			end
			if (wb_adr_i == STAT_OFS && wb_sel_i[0]
				&& wb_dat_i[ST_OVF] && !ovf_set) begin
				ovf_nxt = 1'b0;
			end
		end else if (req) begin
			case (wb_adr_i)
				CTRL_OFS: dat_nxt[CTRL_RUN] = run_r;
				STAT_OFS: begin
					dat_nxt[ST_BY32]  = by32;
					dat_nxt[ST_BP]    = bandpass;
					dat_nxt[ST_EMPTY] = !f_out_valid;
					dat_nxt[ST_FULL]  = !f_in_ready;
					dat_nxt[ST_OVF]   = ovf_r;
				end
				DATA_OFS: dat_nxt[WORD_W-1:0] = f_out_valid ? f_out_data : '0;
				default:  dat_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			run_r    <= CTRL_RST;
			ovf_r    <= 1'b0;
		end else begin
			wb_ack_o <= ack_nxt;
			wb_dat_o <= dat_nxt;
			run_r    <= run_nxt;
			ovf_r    <= ovf_nxt;
		end
	end
endmodule

/* File: hw/sdf_pkg.sv */
//--------------------------------------------------------------
// Purpose: shared constants of the decimation filter
// Assumes: 32-bit classic wishbone, 20 MHz clock
// Notes:   offsets are byte addresses, one word per register
//--------------------------------------------------------------
package sdf_pkg;
	localparam int          WORD_W    = 16;     // output word width
	localparam int          ACC_W     = 18;     // stage datapath width
	localparam int          SUM_W     = 20;     // three-tap sum width
	localparam int          STAGES    = 5;      // half-rate stages
	localparam int          TAP_SHIFT = 2;      // taps sum to four
	localparam int          FIFO_D    = 8;      // words buffered
	localparam int          BY16_IDX  = 3;      // fourth stage
	localparam int          BY32_IDX  = 4;      // fifth stage
	localparam logic [ACC_W-1:0] FS_POS = 18'h07fff; // modulator one
	localparam logic [ACC_W-1:0] FS_NEG = 18'h38000; // modulator zero
	localparam logic [7:0]  CTRL_OFS  = 8'h00;  // control register
	localparam logic [7:0]  STAT_OFS  = 8'h04;  // status register
	localparam logic [7:0]  DATA_OFS  = 8'h08;  // fifo head, read pops
	localparam int          CTRL_RUN  = 0;      // ctrl: filter runs
	localparam int          ST_BY32   = 0;      // stat: decimate by 32
	localparam int          ST_BP     = 1;      // stat: band-pass active
	localparam int          ST_EMPTY  = 2;      // stat: fifo empty
	localparam int          ST_FULL   = 3;      // stat: fifo full
	localparam int          ST_OVF    = 4;      // stat: word dropped, w1c
	localparam logic        CTRL_RST  = 1'b1;   // runs after reset
endpackage

/* File: tb/sdf_filter_asserts.sv */
// Purpose: port checks of the decimation filter
// Assumes: pins stay put during a test
// Notes:   word checks wait until setup was calm 255 cycles
`timescale 1ns/1ps
//--------------------------------------------------------------
// checker
//--------------------------------------------------------------
module sdf_checker
	import sdf_pkg::*;
(
	// clock and reset
	input wire logic                  clock,
	input wire logic                  nrst,
	// select pins and stream
	input wire logic                  modulator_bit,
	input wire logic                  serial_mode,
	input wire logic                  parallel_rate_select_a,
	input wire logic                  parallel_rate_select_b,
	input wire logic                  serial_rate_select,
	input wire logic                  serial_response_select,
	input wire logic [sdf_pkg::WORD_W-1:0] word_r,
	input wire logic                  word_valid_r,
	// register bus
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic                  wb_ack_o
);
	logic       sel32, lp, settled;      // effective rate, response, calm flag
	logic       run_r, run_nxt;          // run bit as software left it
	logic [3:0] key, key_r, key_nxt;     // setup snapshot
	logic [7:0] calm_r, calm_nxt;        // cycles since setup changed
	logic [7:0] gap_r, gap_nxt;          // cycles since last word
	assign sel32 = serial_mode ? serial_rate_select : parallel_rate_select_a;
	assign lp = !sel32 || (serial_mode ? serial_response_select : parallel_rate_select_b);
	assign key = {sel32, lp, modulator_bit, run_r};
	assign settled = (calm_r == 8'hff);
	// next state; a run change restarts calm so a freeze never looks like a gap fault
	always_comb begin
		run_nxt = run_r;
		if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == CTRL_OFS) begin
			run_nxt = wb_dat_i[CTRL_RUN];
		end
		key_nxt = key;
		calm_nxt = (key != key_r) ? 8'h00 : calm_r + {7'h00, calm_r != 8'hff};
		gap_nxt = word_valid_r ? 8'h00 : gap_r + {7'h00, gap_r != 8'hff};
	end
	// registers only
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			run_r <= CTRL_RST;
			key_r <= 4'h0;
			calm_r <= 8'h00;
			gap_r <= 8'h00;
		end else begin
			run_r <= run_nxt;
			key_r <= key_nxt;
			calm_r <= calm_nxt;
			gap_r <= gap_nxt;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence req_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
	a_bus_answer: assert property (req_taken |=> ack_once)
		else $error("bus request not answered in one cycle");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_valid_single: assert property (word_valid_r |=> !word_valid_r)
		else $error("word valid longer than one cycle");
	a_by16_gap: assert property (word_valid_r && settled && !sel32
		|-> gap_r == 8'd15)
		else $error("word spacing not 16");
	a_by32_gap: assert property (word_valid_r && settled && sel32
		|-> gap_r == 8'd31)
		else $error("word spacing not 32");
	a_dc_high: assert property (word_valid_r && settled && lp && modulator_bit
		|-> word_r == 16'h7fff)
		else $error("positive full scale code wrong");
	a_dc_low: assert property (word_valid_r && settled && lp && !modulator_bit
		|-> word_r == 16'h8000)
		else $error("negative full scale code wrong");
	a_bp_reject: assert property (word_valid_r && settled && !lp
		|-> word_r == 16'h0000)
		else $error("band-pass passed dc");
endmodule
bind sigma_delta_decimation_filter sdf_checker sdf_checker_i (.clock(clock), .nrst(nrst),
	.modulator_bit(modulator_bit), .serial_mode(serial_mode),
	.parallel_rate_select_a(parallel_rate_select_a), .parallel_rate_select_b(parallel_rate_select_b),
	.serial_rate_select(serial_rate_select), .serial_response_select(serial_response_select),
	.word_r(word_r), .word_valid_r(word_valid_r), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o));

/* File: tb/sdf_dsp_model.sv */
// Purpose: processor side: drives select pins, watches words
// Assumes: wanted setup comes from the bench
// Notes:   unused pins toggle so stale levels never help
`timescale 1ns/1ps
module sdf_dsp_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// wanted setup
	input  wire logic        use_serial,
	input  wire logic        want_by32,
	input  wire logic        want_lp,
	// select pins
	output logic             serial_mode,
	output logic             parallel_rate_select_a,
	output logic             parallel_rate_select_b,
	output logic             serial_rate_select,
	output logic             serial_response_select,
	// word stream
	input  wire logic [15:0] word_r,
	input  wire logic        word_valid_r,
	output logic [15:0]      last_word,
	output logic [7:0]       last_gap
);
	logic       tgl;           // toggles each cycle
	logic [7:0] cnt;           // cycles since last word
	// free-running toggle; reset keeps it out of the initialiser
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tgl <= 1'b0;
		end else begin
			tgl <= !tgl;
		end
	end
	// pins change just after an edge; unselected ones get a moving pattern
	always_ff @(posedge clock) begin
		serial_mode <= use_serial;
		serial_rate_select <= use_serial ? want_by32 : tgl;
		serial_response_select <= use_serial ? want_lp : !tgl;
		parallel_rate_select_a <= use_serial ? tgl : want_by32;
		parallel_rate_select_b <= use_serial ? !tgl : want_lp;
	end
	// spacing and value of the last word
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= 8'h01;
			last_gap <= 8'h00;
			last_word <= 16'h0000;
		end else if (word_valid_r) begin
			cnt <= 8'h01;
			last_gap <= cnt;
			last_word <= word_r;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

/* File: tb/tb_sigma_delta_decimation_filter.sv */
// Purpose: self-checking bench of the decimation filter
// Assumes: constant modulator level per test, last test alternates
// Notes:   each of the first eight tests resets, fills, freezes, drains, resumes
`timescale 1ns/1ps
module tb_sigma_delta_decimation_filter;
	import sdf_pkg::*;
	logic              clock, nrst, modulator_bit, use_serial, want_by32, want_lp;
	logic              serial_mode, sel_a, sel_b, ser_rate, ser_resp;
	logic              word_valid_r, cyc, stb, we, ack;
	logic [WORD_W-1:0] word_r, last_word;
	logic [7:0]        adr, last_gap;
	logic [31:0]       dat_w, dat_r, rd;
	int                failures, n_tests, ew, st;
	int                exp_q[$];     // words the fifo should hand out
	sigma_delta_decimation_filter sigma_delta_decimation_filter_i (.clock(clock), .nrst(nrst),
		.modulator_bit(modulator_bit), .serial_mode(serial_mode), .parallel_rate_select_a(sel_a),
		.parallel_rate_select_b(sel_b), .serial_rate_select(ser_rate),
		.serial_response_select(ser_resp), .word_r(word_r), .word_valid_r(word_valid_r),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack));
	sdf_dsp_model sdf_dsp_model_i (.clock(clock), .nrst(nrst), .use_serial(use_serial),
		.want_by32(want_by32), .want_lp(want_lp), .serial_mode(serial_mode),
		.parallel_rate_select_a(sel_a), .parallel_rate_select_b(sel_b),
		.serial_rate_select(ser_rate), .serial_response_select(ser_resp), .word_r(word_r),
		.word_valid_r(word_valid_r), .last_word(last_word), .last_gap(last_gap));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// one classic cycle; waits for ack, bounded
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
		do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
		rd = dat_r;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (n >= 50) failures++;
	endtask
	task automatic print_verdict;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
	initial begin
		{nrst, modulator_bit, use_serial, want_by32, want_lp, cyc, stb, we} = 8'h00;
		adr = 8'h00;
		dat_w = 32'h0;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'hb55992d3));
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			nrst <= 1'b0;
			use_serial <= k[0]; want_by32 <= k[1]; want_lp <= k[2];
			modulator_bit <= 1'($urandom);
			repeat (6) @(posedge clock);
			nrst <= 1'b1;
			repeat (400) @(posedge clock);
			// bench model: band-pass only at /32 rejects dc, else full scale codes
			ew = (k[1] && !k[2]) ? 0 : (modulator_bit ? 32'h7fff : 32'h8000);
			st = 32'h18 | k[1] | ((k[1] && !k[2]) ? 2 : 0);
			check({24'h0, last_gap}, k[1] ? 32 : 16);
			check({16'h0, last_word}, ew);
			wb(1'b0, STAT_OFS, 32'h0);
			check(rd, st);
			wb(1'b1, CTRL_OFS, 32'h0);
			repeat (FIFO_D) wb(1'b0, DATA_OFS, 32'h0);
			wb(1'b0, STAT_OFS, 32'h0);
			check(rd, st ^ 32'h0c);
			wb(1'b1, STAT_OFS, 32'h10);
			wb(1'b0, STAT_OFS, 32'h0);
			check(rd, st ^ 32'h1c);
			wb(1'b0, DATA_OFS, 32'h0);
			check(rd, 32'h0);
			wb(1'b0, 8'h0c, 32'h0);
			check(rd, 32'h0);
			wb(1'b1, CTRL_OFS, 32'h1);
			for (int n = 0; n < 100 && word_valid_r !== 1'b1; n++) @(posedge clock);
			// a resumed chain must deliver a word, else an empty read of zero would pass
			check({31'h0, word_valid_r}, 32'h1);
			exp_q.push_back(ew);
			wb(1'b0, DATA_OFS, 32'h0);
			check(rd, exp_q.pop_front());
			$display("test %0d done", k);
		end
		// alternating bits sit half a step below zero: the code just under midscale
		@(posedge clock);
		nrst <= 1'b0;
		use_serial <= 1'b0; want_by32 <= 1'b0; want_lp <= 1'b1;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (400) begin
			@(posedge clock);
			modulator_bit <= !modulator_bit;
		end
		check({16'h0, last_word}, 32'hffff);
		$display("test 8 done");
		print_verdict();
	end
endmodule
